// ---- hdl/spi_port.sv ----
// Serial port master/slave with APB register access
// Function
// - Master clock at most clk/16, slave clk/4
// - Shifter transmits; separate receive read buffer
// - Data write refused while transfer busy
// - Finished byte moves to read buffer
// - Master drives MOSI, slave drives MISO
// - Shift clock output as master, input slave
// - Master makes exactly eight clock cycles
// - Slave active only while select low
// - Both shifters exchange as one ring
// - Control bit 5 picks bit order
// - Control bit 7 drives automatic select when fault detect is disabled
// - Control bit 6 enables the port
// - Control bit 4 picks master or slave
// - Control bit 3 sets clock idle level
// - Control bit 2 picks sampling edge
// - Control bits 1:0 pick divider 16..128
// - Fault detect makes select a fault input
// - Master data write starts byte exchange
`timescale 1ns/1ps
module spi_port
   import spi_port_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Shift clock pin
   input  wire logic        shiftClockPinIn,
   output logic             shiftClockPinOut,
   output logic             shiftClockPinOeN,
   // Master out slave in
   input  wire logic        mosiIn,
   output logic             mosiOut,
   output logic             mosiOeN,
   // Master in slave out
   input  wire logic        misoIn,
   output logic             misoOut,
   output logic             misoOeN,
   // Slave select pin
   input  wire logic        selectIn,
   output logic             selectOut,
   output logic             selectOeN
);
   // Complete block state
   typedef struct packed {
      logic [7:0]  ctrl;       // Control register
      logic        faultDis;   // Fault detect disable
      logic [3:0]  flags;      // Done, collision, overrun, fault
      logic [3:0]  mask;       // Interrupt mask
      logic        selLevel;   // General purpose select level
      logic [7:0]  shift;      // Shift register, also transmit buffer
      logic [7:0]  rbuf;       // Receive read buffer
      xfer_state_t state;      // Transfer state
      logic [3:0]  edgeCnt;    // Clock edges seen this byte
      logic [5:0]  divCnt;     // Half bit divider
      logic        sclkLvl;    // Master clock level
      logic        sample;     // Bit captured on sampling edge
      logic        sclkPrev;   // Last synchronised slave clock
      logic        finish;     // Last sampled bit shifts in next cycle
   } port_state_t;

   port_state_t s_r;           // Registered state
   port_state_t s_nxt;         // Next state
   logic [1:0]  syncPins;      // Synchronised clock and select
   logic        sclkSync;      // Synchronised slave clock
   logic        selSync;       // Synchronised select
   logic        enable;        // Port enabled
   logic        isMaster;      // Master role
   logic        clock_sample_edge;          // Sampling edge choice
   logic        lsbFirst;      // Bit order choice
   logic        wrAcc;         // APB write access phase
   logic        rdAcc;         // APB read access phase
   logic        addrOk;        // Address maps to a register
   logic        edgeNow;       // Shift clock edge this cycle
   logic        inBit;         // Serial input for this role
   logic        xferDone;      // Byte finished this cycle
   logic        faultNow;      // Mode fault seen this cycle
   logic [5:0]  halfLen;       // Half bit length in cycles
   logic [7:0]  doneByte;      // Byte that completes

   sync_stage #(
      .WIDTH (2)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({shiftClockPinIn, selectIn}),
      .q   (syncPins)
   );
   assign sclkSync = syncPins[1];
   assign selSync  = syncPins[0];

   // Decoded control
   assign enable   = s_r.ctrl[BIT_PORT_ENABLE];
   assign isMaster = s_r.ctrl[BIT_MASTER_SELECT];
   assign clock_sample_edge     = s_r.ctrl[BIT_CLOCK_SAMPLE_EDGE];
   assign lsbFirst = s_r.ctrl[BIT_LOW_BIT_FIRST];

   // APB decode, zero wait state
   assign wrAcc   = psel && penable && pwrite;
   assign rdAcc   = psel && penable && !pwrite;
   assign addrOk  = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_DATA) || (paddr == ADDR_MASK);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addrOk;

   // Read data mux
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (rdAcc)
      begin
         case (paddr)
            ADDR_CONTROL: prdata[7:0] = s_r.ctrl;
            ADDR_STATUS:  prdata[7:0] = {s_r.flags, s_r.faultDis, 3'h0};
            ADDR_DATA:    prdata[7:0] = s_r.rbuf;  // Reads return the read buffer
            ADDR_MASK:    prdata[7:0] = {s_r.mask, 3'h0, s_r.selLevel};
            default:      prdata      = 32'h0000_0000;
         endcase
      end
   end

   // divider: half bit of 8, 16, 32 or 64 cycles
   assign halfLen = HALF_BASE << {s_r.ctrl[BIT_RATE_SELECT_HI], s_r.ctrl[BIT_RATE_SELECT_LO]};

   // Edge source for each role
   always_comb
   begin
      if (isMaster)
      begin
         // master edge at most every eight cycles
         edgeNow = (s_r.state == ST_XFER) && (s_r.divCnt == halfLen - 6'h01);
         inBit   = misoIn;
      end
      else
      begin
         // slave counts edges only while selected
         edgeNow = enable && !selSync && (sclkSync != s_r.sclkPrev);
         inBit   = mosiIn;
      end
   end

   // select low while detection on is a fault
   assign faultNow = enable && isMaster && !s_r.faultDis && !selSync;

   // Next state
   always_comb
   begin
      s_nxt    = s_r;
      xferDone = 1'b0;
      doneByte = s_r.shift;
      s_nxt.sclkPrev = sclkSync;
      s_nxt.finish   = 1'b0;

      // delayed final shift, order picks direction
      if (s_r.finish)
      begin
         doneByte = lsbFirst ? {s_r.sample, s_r.shift[7:1]} : {s_r.shift[6:0], s_r.sample};
         xferDone = 1'b1;
      end

      // Master divider runs only in a transfer
      if (isMaster && s_r.state == ST_XFER)
      begin
         s_nxt.divCnt = edgeNow ? 6'h00 : s_r.divCnt + 6'h01;
      end

      // sixteen edges, eight clock cycles per byte
      if (edgeNow)
      begin
         s_nxt.state   = ST_XFER;
         s_nxt.edgeCnt = s_r.edgeCnt + 4'h1;
         if (isMaster)
         begin
            s_nxt.sclkLvl = !s_r.sclkLvl;
         end
         // sample on first or second edge of each bit
         if (s_r.edgeCnt[0] == clock_sample_edge)
         begin
            s_nxt.sample = inBit;
            // Data line must hold past the partner's last sampling edge
            s_nxt.finish = (s_r.edgeCnt == LAST_EDGE);
         end
         // shift sampled bit in as next bit goes out
         else if (!(clock_sample_edge && s_r.edgeCnt == 4'h0))
         begin
            doneByte    = lsbFirst ? {s_r.sample, s_r.shift[7:1]} :
                                     {s_r.shift[6:0], s_r.sample};
            s_nxt.shift = doneByte;
            xferDone    = (s_r.edgeCnt == LAST_EDGE);
         end
      end

      // finished byte moves to the read buffer
      if (xferDone)
      begin
         s_nxt.shift   = doneByte;
         s_nxt.state   = ST_IDLE;
         s_nxt.edgeCnt = 4'h0;
         s_nxt.divCnt  = 6'h00;
         if (s_r.flags[FLAG_DONE])
         begin
            s_nxt.flags[FLAG_OVERRUN] = 1'b1;  // Unread byte kept
         end
         else
         begin
            s_nxt.rbuf = doneByte;
         end
      end

      // deselect aborts a partial slave byte
      if (!isMaster && selSync)
      begin
         s_nxt.state   = ST_IDLE;
         s_nxt.edgeCnt = 4'h0;
      end

      // Register writes
      if (wrAcc)
      begin
         case (paddr)
            ADDR_CONTROL:
            begin
               s_nxt.ctrl = pwdata[7:0];
            end
            ADDR_STATUS:
            begin
               // Flags clear by writing one
               s_nxt.flags    = s_nxt.flags & ~pwdata[7:4];
               s_nxt.faultDis = pwdata[BIT_FAULT_DETECT_DISABLE];
            end
            ADDR_DATA:
            begin
               // refuse a load while the shifter is busy
               if (s_r.state == ST_XFER)
               begin
                  s_nxt.flags[FLAG_COLLISION] = 1'b1;
               end
               else if (!s_r.flags[FLAG_DONE])
               begin
                  // write goes straight into the shifter
                  s_nxt.shift = pwdata[7:0];
                  if (isMaster && enable)
                  begin
                     s_nxt.state   = ST_XFER;
                     s_nxt.divCnt  = 6'h00;
                     s_nxt.edgeCnt = 4'h0;
                  end
               end
            end
            ADDR_MASK:
            begin
               s_nxt.mask     = pwdata[7:4];
               s_nxt.selLevel = pwdata[BIT_SELECT_LEVEL];
            end
            default:
            begin
               s_nxt.ctrl = s_nxt.ctrl;  // Unmapped, no effect
            end
         endcase
      end

      // Hardware events win over a clearing write
      if (xferDone && !s_r.flags[FLAG_DONE])
      begin
         s_nxt.flags[FLAG_DONE] = 1'b1;
      end
      if (xferDone && s_r.flags[FLAG_DONE])
      begin
         s_nxt.flags[FLAG_OVERRUN] = 1'b1;
      end
      if (faultNow)
      begin
         // fault drops master role and stops
         s_nxt.flags[FLAG_FAULT]             = 1'b1;
         s_nxt.ctrl[BIT_MASTER_SELECT]       = 1'b0;
         s_nxt.state                         = ST_IDLE;
         s_nxt.edgeCnt                       = 4'h0;
         s_nxt.finish                        = 1'b0;
      end

      // idle clock sits at the chosen level
      if (s_nxt.state == ST_IDLE)
      begin
         s_nxt.sclkLvl = s_nxt.ctrl[BIT_CLOCK_IDLE_LEVEL];
      end

      if (!s_nxt.ctrl[BIT_PORT_ENABLE])
      begin
         s_nxt.finish  = 1'b0;
         s_nxt.state   = ST_IDLE;
         s_nxt.edgeCnt = 4'h0;
         s_nxt.divCnt  = 6'h00;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '{ctrl: CONTROL_RESET, faultDis: 1'b0, flags: FLAGS_RESET,
                  mask: MASK_RESET, selLevel: 1'b1, shift: DATA_RESET,
                  rbuf: DATA_RESET, state: ST_IDLE, edgeCnt: 4'h0,
                  divCnt: 6'h00, sclkLvl: 1'b0, sample: 1'b0, sclkPrev: 1'b0,
                  finish: 1'b0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Interrupt level from unmasked flags
   assign irq = |(s_r.flags & s_r.mask);

   // Pin drive
   always_comb
   begin
      shiftClockPinOut = s_r.sclkLvl;
      mosiOut          = lsbFirst ? s_r.shift[0] : s_r.shift[7];
      misoOut          = mosiOut;
      selectOut        = s_r.selLevel;
      shiftClockPinOeN = 1'b1;
      mosiOeN          = 1'b1;
      misoOeN          = 1'b1;
      selectOeN        = 1'b1;
      if (enable && isMaster)
      begin
         // master drives clock; master drives MOSI
         shiftClockPinOeN = 1'b0;
         mosiOeN          = 1'b0;
         if (s_r.faultDis)
         begin
            selectOeN = 1'b0;
            if (s_r.ctrl[BIT_SELECT_OUTPUT_ENABLE])
            begin
               selectOut = (s_r.state != ST_XFER);
            end
         end
      end
      else if (enable && !selSync)
      begin
         misoOeN = 1'b0;
      end
   end

   // Assertion context
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // master half bit lasts at least eight cycles
   rate_limit_a: assert property (
      (isMaster && s_r.state == ST_XFER && $changed(shiftClockPinOut))
      |=> $stable(shiftClockPinOut)[*7])
      else $error("Master shift clock too fast");
   write_collision_a: assert property (
      (wrAcc && paddr == ADDR_DATA && s_r.state == ST_XFER && enable)
      |=> s_r.flags[FLAG_COLLISION])
      else $error("Collision flag not set");
   byte_done_a: assert property (
      (xferDone && !faultNow) |=> s_r.flags[FLAG_DONE] && s_r.state == ST_IDLE)
      else $error("Done flag missing after byte");
   // master drives MOSI and releases MISO
   master_pins_a: assert property (
      (enable && isMaster) |-> !mosiOeN && misoOeN && !shiftClockPinOeN)
      else $error("Master pin drive wrong");
   slave_idle_a: assert property (
      (!isMaster && selSync) |-> misoOeN)
      else $error("Deselected slave drives MISO");
   // automatic select low in a transfer
   auto_select_a: assert property (
      (enable && isMaster && s_r.faultDis && s_r.ctrl[BIT_SELECT_OUTPUT_ENABLE])
      |-> !selectOeN && (selectOut == (s_r.state != ST_XFER)))
      else $error("Automatic select wrong");
   port_off_a: assert property (
      !enable |-> shiftClockPinOeN && mosiOeN && misoOeN && selectOeN)
      else $error("Disabled port drives a pin");
   // idle master clock at idle level
   idle_level_a: assert property (
      (enable && isMaster && s_r.state == ST_IDLE && $stable(s_r.ctrl))
      |-> shiftClockPinOut == s_r.ctrl[BIT_CLOCK_IDLE_LEVEL])
      else $error("Idle clock level wrong");
   // select low with detection raises fault
   mode_fault_a: assert property (
      faultNow |=> s_r.flags[FLAG_FAULT] && !isMaster)
      else $error("Mode fault not taken");
   master_start_a: assert property (
      (wrAcc && paddr == ADDR_DATA && isMaster && enable && !faultNow &&
       s_r.state == ST_IDLE && !s_r.flags[FLAG_DONE]) |=> s_r.state == ST_XFER)
      else $error("Master write did not start");

   // Main scenarios
   master_byte_c: cover property (isMaster && xferDone);
   slave_byte_c:  cover property (!isMaster && xferDone);
   fault_c:       cover property (faultNow);
   overrun_c:     cover property (xferDone && s_r.flags[FLAG_DONE]);
endmodule

// ---- hdl/spi_port_pkg.sv ----
// Constants and types shared by the serial port design
package spi_port_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CONTROL = 8'hf3;  // Control register
   localparam logic [7:0]  IDX_STATUS  = 8'hf4;  // Status flags and fault detect disable
   localparam logic [7:0]  IDX_DATA    = 8'hf5;  // Shift data register
   localparam logic [7:0]  IDX_MASK    = 8'hf6;  // Interrupt mask and select level
   localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADDR_DATA    = {2'h0, IDX_DATA, 2'h0};
   localparam logic [11:0] ADDR_MASK    = {2'h0, IDX_MASK, 2'h0};

   // Control register fields
   localparam int BIT_SELECT_OUTPUT_ENABLE = 7;
   localparam int BIT_PORT_ENABLE          = 6;
   localparam int BIT_LOW_BIT_FIRST        = 5;
   localparam int BIT_MASTER_SELECT        = 4;
   localparam int BIT_CLOCK_IDLE_LEVEL     = 3;
   localparam int BIT_CLOCK_SAMPLE_EDGE    = 2;
   localparam int BIT_RATE_SELECT_HI       = 1;
   localparam int BIT_RATE_SELECT_LO       = 0;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;

   // Status register fields; flags sit in bits 7:4
   localparam int BIT_FAULT_DETECT_DISABLE = 3;
   localparam int FLAG_LOW                 = 4;
   localparam int FLAG_DONE                = 3;  // Index within the flag nibble
   localparam int FLAG_COLLISION           = 2;
   localparam int FLAG_OVERRUN             = 1;
   localparam int FLAG_FAULT               = 0;
   localparam logic [3:0] FLAGS_RESET      = 4'h0;
   localparam logic [7:0] DATA_RESET       = 8'h00;
   localparam logic [3:0] MASK_RESET       = 4'h0;
   localparam int BIT_SELECT_LEVEL         = 0;  // Mask register, general purpose select level

   // Shift clock timing
   localparam int PERIPH_CLOCK_MHZ = 50;
   localparam int MASTER_MIN_DIV   = 16;         // Fastest divider setting 00
   localparam int SLAVE_MIN_DIV    = 4;          // Fastest shift clock accepted as slave
   localparam logic [5:0] HALF_BASE = 6'(MASTER_MIN_DIV / 2);  // Cycles per half bit at 00
   localparam int BITS_PER_BYTE    = 8;
   localparam logic [3:0] LAST_EDGE = 4'(2 * BITS_PER_BYTE - 1);

   // Transfer state
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01
   } xfer_state_t;
endpackage

// ---- hdl/sync_stage.sv ----
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sync_stage #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;  // First stage, read only by the second

   // Width check
   initial
   begin
      if (WIDTH < 1)
      begin
         $error("sync_stage width must be at least one");
      end
   end

   // Two stage capture
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ---- verif/spi_peer_model.sv ----
// Behavioural serial peripheral that answers the port in master mode
`timescale 1ns/1ps
module spi_peer_model (
   // Serial lines
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       selN,
   output logic            miso,
   // Frame setup
   input  wire logic       clock_idle_level,
   input  wire logic       clock_sample_edge,
   input  wire logic [7:0] txByte,
   output logic      [7:0] rxByte
);
   logic [7:0] txShift;  // Outgoing byte
   int         outCnt;   // Output edges seen

   // Start values
   initial
   begin
      miso = 1'b0;
      rxByte = 8'h00;
   end

   always @(negedge selN)
   begin
      txShift = txByte;
      outCnt = 0;
      miso = clock_sample_edge ? ~txByte[7] : txByte[7];
   end

   // released line shows no stale bit
   always @(posedge selN)
      miso = ~miso;

   always @(sclk)
   begin
      if (selN === 1'b0)
      begin
         if ((sclk !== clock_idle_level) ^ clock_sample_edge)
            rxByte = {rxByte[6:0], mosi};
         else
         begin
            if (!(clock_sample_edge && outCnt == 0))
               txShift = txShift << 1;
            miso = txShift[7];
            outCnt++;
         end
      end
   end
endmodule

// ---- verif/test_spi_master_slave_port.sv ----
// Self-checking bench for the serial port
`timescale 1ns/1ps
module test_spi_master_slave_port;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN, selOut, selOeN;
   logic        tbSclk, tbMosi, tbSel, peerMiso, clock_idle_level, clock_sample_edge, slvErr;
   logic [7:0]  peerTx, peerRx;
   int          nFail = 0;
   int          nTests = 0;
   int          edges = 0;
   time         tA, tB;
   // Resolved pin levels
   wire sclkW = !sckOeN ? sckOut : tbSclk;
   wire mosiW = !mosiOeN ? mosiOut : tbMosi;
   wire misoW = !misoOeN ? misoOut : peerMiso;
   wire selW  = !selOeN ? selOut : tbSel;

   spi_port dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .shiftClockPinIn(sclkW), .shiftClockPinOut(sckOut),
      .shiftClockPinOeN(sckOeN), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
      .misoIn(misoW), .misoOut(misoOut), .misoOeN(misoOeN), .selectIn(selW),
      .selectOut(selOut), .selectOeN(selOeN));

   spi_peer_model peer (.sclk(sclkW), .mosi(mosiW), .selN(selW), .miso(peerMiso),
      .clock_idle_level(clock_idle_level), .clock_sample_edge(clock_sample_edge), .txByte(peerTx), .rxByte(peerRx));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Shift clock edge count and spacing
   always @(sclkW)
   begin
      edges++;
      if (edges == 1) tA = $time;
      if (edges == 2) tB = $time;
   end

   // Verdict and end of run
   task automatic summarize();
      $display("Checks %0d, errors %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp)
      begin
         nFail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, settled at the following falling edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (k >= 16)
      begin
         check(32'h0, 32'h1);
         summarize();
      end
      rd = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] unused;
      apb(1'b1, a, d, unused);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      apb(1'b0, a, 32'h0, d);
   endtask

   // Poll status until the done flag rises
   task automatic waitDone();
      logic [31:0] v;
      for (int k = 0; k < 400; k++)
      begin
         rd(spi_port_pkg::ADDR_STATUS, v);
         if (v[7] === 1'b1) return;
      end
      check(32'h0, 32'h1);
      summarize();
   endtask

   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int b = 0; b < 8; b++) rev[b] = v[7 - b];
   endfunction

   // Reset values, unmapped access, enable and role
   task automatic regsReset();
      logic [11:0] a [4] = '{spi_port_pkg::ADDR_CONTROL, spi_port_pkg::ADDR_STATUS,
                             spi_port_pkg::ADDR_DATA, spi_port_pkg::ADDR_MASK};
      logic [31:0] e [4] = '{32'h00, 32'h00, 32'h00, 32'h01};
      logic [31:0] v;
      for (int i = 0; i < 4; i++)
      begin
         rd(a[i], v);
         check(v, e[i]);
      end
      wr(12'h000, 32'hff);
      rd(12'h000, v);
      check({v[30:0], slvErr}, 32'h1);
      wr(spi_port_pkg::ADDR_CONTROL, 32'h10);
      check(32'(mosiOeN), 32'h1);
      wr(spi_port_pkg::ADDR_CONTROL, 32'h50);
      check(32'({mosiOeN, sckOeN}), 32'h0);
   endtask

   // Master exchange: mode and rate both taken from i
   task automatic masterXfer(input int i, input logic lsb, input logic [7:0] txM,
                             input logic [7:0] txS);
      logic [31:0] v;
      clock_idle_level = i[1];
      clock_sample_edge = i[0];
      peerTx = txS;
      wr(spi_port_pkg::ADDR_STATUS, 32'hf8);
      wr(spi_port_pkg::ADDR_CONTROL, {24'h0, 2'b11, lsb, 1'b1, i[1:0], i[1:0]});
      edges = 0;
      wr(spi_port_pkg::ADDR_DATA, 32'(txM));
      check(32'(selW), 32'h0);
      waitDone();
      check(32'(edges), 32'h10);
      check(32'((tB - tA) / 20), 32'(8 << i));
      check(32'(peerRx), 32'(lsb ? rev(txM) : txM));
      rd(spi_port_pkg::ADDR_DATA, v);
      check(v, 32'(lsb ? rev(txS) : txS));
      check(32'({sclkW, selW}), 32'({clock_idle_level, 1'b1}));
   endtask

   // Collision during a transfer, masked interrupt
   task automatic collisionIrq();
      logic [31:0] v;
      clock_idle_level = 1'b0;
      clock_sample_edge = 1'b0;
      peerTx = 8'h4e;
      wr(spi_port_pkg::ADDR_STATUS, 32'hf8);
      wr(spi_port_pkg::ADDR_MASK, 32'h41);
      wr(spi_port_pkg::ADDR_CONTROL, 32'hd0);
      wr(spi_port_pkg::ADDR_DATA, 32'h5a);
      check(32'(irq), 32'h0);
      wr(spi_port_pkg::ADDR_DATA, 32'hff);
      rd(spi_port_pkg::ADDR_STATUS, v);
      check(v & 32'h40, 32'h40);
      check(32'(irq), 32'h1);
      waitDone();
      check(32'(peerRx), 32'h5a);
      wr(spi_port_pkg::ADDR_STATUS, 32'hc8);
      check(32'(irq), 32'h0);
      wr(spi_port_pkg::ADDR_MASK, 32'h01);
   endtask

   // Select pulled low while fault detection is on
   task automatic modeFault();
      logic [31:0] v;
      wr(spi_port_pkg::ADDR_STATUS, 32'hf0);
      wr(spi_port_pkg::ADDR_CONTROL, 32'h50);
      check(32'(selOeN), 32'h1);
      @(posedge clk);
      tbSel <= 1'b0;
      repeat (4) @(negedge clk);
      rd(spi_port_pkg::ADDR_STATUS, v);
      check(v & 32'h10, 32'h10);
      rd(spi_port_pkg::ADDR_CONTROL, v);
      check(v, 32'h40);
      @(posedge clk);
      tbSel <= 1'b1;
   endtask

   // Port as slave, bench as master in mode 0
   task automatic slaveRx();
      logic [31:0] v;
      logic [7:0]  got;
      logic [7:0]  tx;
      tx = 8'h6b;
      wr(spi_port_pkg::ADDR_STATUS, 32'hf8);
      wr(spi_port_pkg::ADDR_CONTROL, 32'h40);
      wr(spi_port_pkg::ADDR_DATA, 32'hc3);
      check(32'({misoOeN, sckOeN}), 32'h3);
      @(posedge clk);
      tbSel <= 1'b0;
      repeat (6) @(negedge clk);
      check(32'(misoOeN), 32'h0);
      for (int b = 7; b >= 0; b--)
      begin
         @(posedge clk);
         tbMosi <= tx[b];
         repeat (8) @(negedge clk);
         got[b] = misoW;
         @(posedge clk);
         tbSclk <= 1'b1;
         repeat (8) @(posedge clk);
         tbSclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      tbSel <= 1'b1;
      repeat (6) @(negedge clk);
      check(32'(misoOeN), 32'h1);
      check(32'(got), 32'hc3);
      rd(spi_port_pkg::ADDR_DATA, v);
      check(v, 32'(tx));
      rd(spi_port_pkg::ADDR_STATUS, v);
      check(v & 32'h80, 32'h80);
   endtask

   // Main sequence
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {tbSclk, tbMosi, tbSel, clock_idle_level, clock_sample_edge} = 5'b00100;
      peerTx = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      regsReset();
      for (int i = 0; i < 4; i++)
         masterXfer(i, i == 1, 8'(8'h1d + i), 8'(8'hb2 + i));
      collisionIrq();
      modeFault();
      slaveRx();
      summarize();
   end
endmodule
